// >>> pkg/rwd_consts.svh
`ifndef RWD_CONSTS_SVH
`define RWD_CONSTS_SVH

// timing
`define RWD_CLK_PERIOD_NS 10
`define RWD_RELEASE_NS 160
`define RWD_RELEASE_CYC ((`RWD_RELEASE_NS + `RWD_CLK_PERIOD_NS - 1) / `RWD_CLK_PERIOD_NS)

// register byte offsets
`define RWD_OFF_CTRL 12'h000
`define RWD_OFF_CAUSE 12'h004
`define RWD_OFF_MASK 12'h008
`define RWD_OFF_WAKE_EN 12'h00C
`define RWD_OFF_WAKE_FLAGS 12'h010
`define RWD_OFF_STATE 12'h014
`define RWD_OFF_UID0 12'h018
`define RWD_OFF_UID1 12'h01C
`define RWD_OFF_UID2 12'h020
`define RWD_OFF_RF 12'h040

// field positions
`define RWD_CTRL_SWRST 0
`define RWD_STATE_SECURE 7
`define RWD_STATE_SRAM 6
`define RWD_STATE_POWER 5
`define RWD_STATE_WAKERST 4

// reset values
`define RWD_MASK_RST 10'h000
`define RWD_WAKE_EN_RST 12'h000

// security
`define RWD_FLASH_CFG_ADDR 12'h40E
`define RWD_UNSEC_CODE 2'h2

`endif

// >>> pkg/rwd_pkg.sv
package rwd_pkg;

	// sources that arrive from outside the block
	typedef struct packed {
		logic low_voltage_detect;
		logic watchdog_timeout;
		logic stop_ack_error;
		logic lockup;
		logic debug_port_system_reset;
		logic debug;
	} rwd_ext_src_s;

	// every source, as seen by the distribution logic
	typedef struct packed {
		logic debug;
		logic debug_port_system_reset;
		logic lockup;
		logic software;
		logic stop_ack_error;
		logic watchdog_timeout;
		logic pin;
		logic wakeup;
		logic low_voltage_detect;
	} rwd_src_s;

	// one reset line per group or preserved register subset
	typedef struct packed {
		logic power_controller;
		logic power_thresholds;
		logic system_integration_unit;
		logic first_options_register;
		logic mode_controller;
		logic mode_registers;
		logic reset_control_unit;
		logic pin_filter_regs;
		logic low_leakage_wakeup_unit;
		logic rtc;
		logic low_power_timer;
		logic others;
	} rwd_grp_s;

	typedef enum logic [1:0] {
		LP_LEAKAGE_STOP = 2'h0,
		LP_DEEP_STOP3 = 2'h1,
		LP_DEEP_STOP1 = 2'h2,
		LP_DEEP_STOP0 = 2'h3
	} rwd_lp_mode_e;

	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_LEAK_STOP = 4'h2,
		ST_DEEP_STOP = 4'h4,
		ST_DEEP_RECOV = 4'h8
	} rwd_state_e;

endpackage : rwd_pkg

// >>> rtl/rwd_top.sv
`timescale 1ns/1ns
`include "rwd_consts.svh"

module rwd_top #(
	parameter int WAKE_PINS = 8,
	parameter int WAKE_MODS = 4,
	parameter int UID_BITS = 80,
	parameter int RF_WORDS = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// reset sources
	input wire rwd_pkg::rwd_ext_src_s ext_src,
	// reset pin, open drain
	input wire logic reset_pin_n,
	output logic reset_pin_drive_n,
	output logic reset_pin_oe,
	// group resets
	output rwd_pkg::rwd_grp_s grp_rst,
	// low power and wakeup
	input wire logic lp_enter,
	input wire rwd_pkg::rwd_lp_mode_e lp_mode,
	input wire logic [WAKE_PINS-1:0] wake_pins,
	input wire logic [WAKE_MODS-1:0] wake_mods,
	output logic wake_req,
	output logic sram_retain,
	output logic periph_power,
	// security and identity
	input wire logic [7:0] flash_cfg_byte,
	input wire logic [UID_BITS-1:0] uid_fuses,
	input wire logic dbg_mem_req,
	output logic dbg_mem_grant,
	input wire logic boot_read_req,
	output logic boot_read_grant,
	input wire logic mass_erase_set,
	input wire logic mass_erase_done,
	output logic mass_erase_start,
	// interrupt
	output logic irq
);

	localparam int NGRP = $bits(rwd_pkg::rwd_grp_s);
	localparam int NSRC = $bits(rwd_pkg::rwd_src_s);
	localparam int NWK = WAKE_PINS + WAKE_MODS;
	localparam int REL = `RWD_RELEASE_CYC;
	localparam int CW = $clog2(REL + 1);
	localparam int RFW = (RF_WORDS > 1) ? $clog2(RF_WORDS) : 1;

	// group map per source
	function automatic rwd_pkg::rwd_grp_s grp_of(input rwd_pkg::rwd_src_s s);
		logic six;
		logic all;
		rwd_pkg::rwd_grp_s g;
		six = s.watchdog_timeout | s.stop_ack_error | s.software | s.lockup
			| s.debug_port_system_reset | s.debug;
		all = six | s.pin | s.wakeup | s.low_voltage_detect;
		g.power_controller = s.low_voltage_detect | s.pin | six;
		g.power_thresholds = 1'b0;
		g.system_integration_unit = all;
		g.first_options_register = s.low_voltage_detect;
		g.mode_controller = s.low_voltage_detect | s.pin | six;
		g.mode_registers = s.low_voltage_detect;
		g.reset_control_unit = all;
		g.pin_filter_regs = s.low_voltage_detect | s.pin | s.wakeup;
		g.low_leakage_wakeup_unit = s.low_voltage_detect | s.pin | six;
		g.rtc = 1'b0;
		g.low_power_timer = s.low_voltage_detect;
		g.others = all;
		return g;
	endfunction : grp_of

	// write-one-to-clear with set winning
	function automatic logic [31:0] sticky(input logic [31:0] cur, input logic [31:0] set,
		input logic [31:0] clr);
		return (cur & ~clr) | set;
	endfunction : sticky

	rwd_pkg::rwd_state_e st_ff;
	rwd_pkg::rwd_lp_mode_e mode_ff;
	rwd_pkg::rwd_src_s src;
	rwd_pkg::rwd_grp_s grp_hit;
	logic [NGRP:0] hit;
	logic [NGRP:0] act_ff;
	logic [CW-1:0] cnt_ff [NGRP+1];
	logic pin_src;
	logic wake_rst_ff;
	logic wake_by_pin_ff;
	logic swrst_ff;
	logic [NWK:0] flags_ff;
	logic [NWK-1:0] wake_en_ff;
	logic [NWK-1:0] wake_hit;
	logic detect;
	logic pin_wake;
	logic leak_wake;
	logic [9:0] cause_ff;
	logic [9:0] mask_ff;
	logic irq_ff;
	logic wake_req_ff;
	logic sram_retain_ff;
	logic periph_power_ff;
	logic load_ff;
	logic secure_ff;
	logic [UID_BITS-1:0] uid_ff;
	logic [95:0] uid_pad;
	logic [31:0] rf_ff [RF_WORDS];
	logic dbg_mem_grant_ff;
	logic boot_read_grant_ff;
	logic mass_erase_start_ff;
	logic pin_drive_n_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic wr_go;
	logic rd_phase;
	logic rf_sel;
	logic [RFW-1:0] rf_idx;
	logic [31:0] rd_data;
	logic rd_err;

	assign wr_go = psel & penable & pwrite & pready_ff;
	assign rd_phase = psel & penable & ~pready_ff;
	assign rf_sel = (paddr >= `RWD_OFF_RF) && (paddr < `RWD_OFF_RF + 12'(4 * RF_WORDS))
		&& (paddr[1:0] == 2'h0);
	assign rf_idx = RFW'((paddr - `RWD_OFF_RF) >> 2);
	assign uid_pad = 96'(uid_ff);

	// pin low while we do not drive it; a pin that woke us from deep stop is not a pin reset
	assign pin_src = ~reset_pin_n & ~act_ff[NGRP] & (st_ff != rwd_pkg::ST_DEEP_STOP)
		& ~wake_rst_ff;

	always_comb begin
		src.low_voltage_detect = ext_src.low_voltage_detect;
		src.wakeup = wake_rst_ff;
		src.pin = pin_src;
		src.watchdog_timeout = ext_src.watchdog_timeout;
		src.stop_ack_error = ext_src.stop_ack_error;
		src.software = swrst_ff;
		src.lockup = ext_src.lockup;
		src.debug_port_system_reset = ext_src.debug_port_system_reset;
		src.debug = ext_src.debug;
	end

	assign grp_hit = grp_of(src);
	// pin driven on wake reset only after pin wake
	assign hit = {(src.low_voltage_detect | src.pin | src.watchdog_timeout | src.stop_ack_error
		| src.software | src.lockup | src.debug_port_system_reset | src.debug
		| (wake_rst_ff & wake_by_pin_ff)), NGRP'(grp_hit)};

	// one release stretch per line; bit NGRP drives the reset pin
	for (genvar g = 0; g <= NGRP; g++) begin : g_rel
		always_ff @(posedge clk) begin
			if (rst) begin
				act_ff[g] <= 1'b1;
				cnt_ff[g] <= '0;
			end else if (hit[g]) begin
				act_ff[g] <= 1'b1;
				cnt_ff[g] <= '0;
			end else if (act_ff[g]) begin
				if (cnt_ff[g] == CW'(REL - 1)) begin
					act_ff[g] <= 1'b0;
				end
				cnt_ff[g] <= cnt_ff[g] + CW'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_drive_n_ff <= 1'b0;
		end else begin
			pin_drive_n_ff <= 1'b0;
		end
	end

	// wakeup unit
	// pin and module wake sources
	assign wake_hit = {wake_mods, wake_pins} & wake_en_ff;
	// inputs ignored only in the run state
	assign detect = (st_ff != rwd_pkg::ST_RUN);
	assign pin_wake = (st_ff == rwd_pkg::ST_DEEP_STOP) & ~reset_pin_n;
	assign leak_wake = (st_ff == rwd_pkg::ST_LEAK_STOP) & (|wake_hit);

	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= rwd_pkg::ST_RUN;
			mode_ff <= rwd_pkg::LP_LEAKAGE_STOP;
			wake_rst_ff <= 1'b0;
			wake_by_pin_ff <= 1'b0;
			wake_req_ff <= 1'b0;
		end else begin
			wake_rst_ff <= 1'b0;
			wake_req_ff <= 1'b0;
			case (st_ff)
				rwd_pkg::ST_RUN: begin
					if (lp_enter) begin
						mode_ff <= lp_mode;
						st_ff <= (lp_mode == rwd_pkg::LP_LEAKAGE_STOP) ?
							rwd_pkg::ST_LEAK_STOP : rwd_pkg::ST_DEEP_STOP;
					end
				end
				rwd_pkg::ST_LEAK_STOP: begin
					// disabled as soon as it wakes
					if (leak_wake) begin
						wake_req_ff <= 1'b1;
						st_ff <= rwd_pkg::ST_RUN;
					end
				end
				rwd_pkg::ST_DEEP_STOP: begin
					if ((|wake_hit) | pin_wake) begin
						wake_rst_ff <= 1'b1;
						wake_by_pin_ff <= pin_wake;
						st_ff <= rwd_pkg::ST_DEEP_RECOV;
					end
				end
				rwd_pkg::ST_DEEP_RECOV: begin
					// stays armed until all flags acknowledged
					if (flags_ff == '0) begin
						st_ff <= rwd_pkg::ST_RUN;
					end
				end
				default: begin
					st_ff <= rwd_pkg::ST_RUN;
				end
			endcase
		end
	end

	// wake flags, acknowledged by writing ones
	always_ff @(posedge clk) begin
		if (rst) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= (NWK + 1)'(sticky(32'(flags_ff),
				32'({pin_wake, wake_hit & {NWK{detect}}}),
				(wr_go && paddr == `RWD_OFF_WAKE_FLAGS) ? pwdata : 32'h0000_0000));
		end
	end

	// power and retention for the stop modes
	always_ff @(posedge clk) begin
		if (rst) begin
			periph_power_ff <= 1'b1;
			sram_retain_ff <= 1'b1;
		end else begin
			periph_power_ff <= (st_ff != rwd_pkg::ST_DEEP_STOP);
			sram_retain_ff <= !((st_ff == rwd_pkg::ST_DEEP_STOP) &&
				(mode_ff == rwd_pkg::LP_DEEP_STOP1 || mode_ff == rwd_pkg::LP_DEEP_STOP0));
		end
	end

	// register file is cleared only by power-on
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < RF_WORDS; i++) begin
				rf_ff[i] <= 32'h0000_0000;
			end
		end else if (wr_go && rf_sel) begin
			rf_ff[rf_idx] <= pwdata;
		end
	end

	// identity and security captured once after power-on release
	always_ff @(posedge clk) begin
		if (rst) begin
			load_ff <= 1'b1;
			uid_ff <= '0;
			secure_ff <= 1'b1;
		end else begin
			load_ff <= 1'b0;
			if (load_ff) begin
				uid_ff <= uid_fuses;
				// secure unless the flash field says otherwise
				secure_ff <= (flash_cfg_byte[1:0] != `RWD_UNSEC_CODE);
			end else if (mass_erase_done) begin
				secure_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dbg_mem_grant_ff <= 1'b0;
			boot_read_grant_ff <= 1'b0;
			mass_erase_start_ff <= 1'b0;
		end else begin
			// gate debug memory and boot reads
			dbg_mem_grant_ff <= dbg_mem_req & ~secure_ff & ~load_ff;
			boot_read_grant_ff <= boot_read_req & ~secure_ff & ~load_ff;
			mass_erase_start_ff <= mass_erase_set;
		end
	end

	// control, cause, mask and enables
	always_ff @(posedge clk) begin
		if (rst) begin
			swrst_ff <= 1'b0;
			mask_ff <= `RWD_MASK_RST;
			wake_en_ff <= NWK'(`RWD_WAKE_EN_RST);
		end else begin
			swrst_ff <= wr_go && (paddr == `RWD_OFF_CTRL) && pwdata[`RWD_CTRL_SWRST];
			if (wr_go && paddr == `RWD_OFF_MASK) begin
				mask_ff <= pwdata[9:0];
			end
			if (wr_go && paddr == `RWD_OFF_WAKE_EN) begin
				wake_en_ff <= pwdata[NWK-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cause_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			cause_ff <= 10'(sticky(32'(cause_ff), 32'({leak_wake, NSRC'(src)}),
				(wr_go && paddr == `RWD_OFF_CAUSE) ? pwdata : 32'h0000_0000));
			irq_ff <= |(cause_ff & mask_ff);
		end
	end

	// read decode; unmapped addresses answer with an error
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		if (rf_sel) begin
			rd_data = rf_ff[rf_idx];
		end else begin
			case (paddr)
				`RWD_OFF_CTRL: rd_data = 32'h0000_0000;
				`RWD_OFF_CAUSE: rd_data = 32'(cause_ff);
				`RWD_OFF_MASK: rd_data = 32'(mask_ff);
				`RWD_OFF_WAKE_EN: rd_data = 32'(wake_en_ff);
				`RWD_OFF_WAKE_FLAGS: rd_data = 32'(flags_ff);
				`RWD_OFF_STATE: begin
					rd_data[3:0] = st_ff;
					rd_data[`RWD_STATE_WAKERST] = wake_by_pin_ff;
					rd_data[`RWD_STATE_POWER] = periph_power_ff;
					rd_data[`RWD_STATE_SRAM] = sram_retain_ff;
					rd_data[`RWD_STATE_SECURE] = secure_ff;
				end
				`RWD_OFF_UID0: rd_data = uid_pad[31:0];
				`RWD_OFF_UID1: rd_data = uid_pad[63:32];
				`RWD_OFF_UID2: rd_data = uid_pad[95:64];
				default: rd_err = 1'b1;
			endcase
		end
	end

	// one wait state keeps read data a clean flop output
	always_ff @(posedge clk) begin
		if (rst) begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= rd_phase;
			if (rd_phase) begin
				prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
				pslverr_ff <= rd_err;
			end else begin
				pslverr_ff <= 1'b0;
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign reset_pin_drive_n = pin_drive_n_ff;
	assign reset_pin_oe = act_ff[NGRP];
	assign grp_rst = rwd_pkg::rwd_grp_s'(act_ff[NGRP-1:0]);
	assign wake_req = wake_req_ff;
	assign sram_retain = sram_retain_ff;
	assign periph_power = periph_power_ff;
	assign dbg_mem_grant = dbg_mem_grant_ff;
	assign boot_read_grant = boot_read_grant_ff;
	assign mass_erase_start = mass_erase_start_ff;
	assign irq = irq_ff;

endmodule : rwd_top

// >>> testbench/reset_wakeup_distribution_tb.sv
`timescale 1ns/1ns
`include "rwd_consts.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("unexpected %0t: got %0h want %0h", $time, a, b); end end
`define WAITU(c) begin for (int w = 0; w < 60 && !(c); w++) begin @(posedge clk); #1; end \
	if (!(c)) begin fail_count++; $display("unexpected %0t: timeout", $time); end_sim(); end end
module reset_wakeup_distribution_tb;
	logic clk = 0;
	logic rst = 1;
	logic [11:0] paddr = '0;
	logic psel = 0, penable = 0, pwrite = 0, press = 0, lp_enter = 0;
	logic [31:0] pwdata = '0, prdata, rv, rf_d;
	logic pready, pslverr, reset_pin_n, reset_pin_drive_n, reset_pin_oe;
	rwd_pkg::rwd_ext_src_s ext_src = '0;
	rwd_pkg::rwd_grp_s grp_rst;
	rwd_pkg::rwd_lp_mode_e lp_mode = rwd_pkg::LP_LEAKAGE_STOP;
	logic [7:0] wake_pins = '0, flash_cfg_byte = 8'h00;
	logic [3:0] wake_mods = '0;
	logic [79:0] uid_fuses = '0;
	logic dbg_mem_req = 1, boot_read_req = 1, mass_erase_set = 0, mass_erase_done = 0;
	logic wake_req, sram_retain, periph_power, dbg_mem_grant, boot_read_grant;
	logic mass_erase_start, irq;
	int fail_count = 0, n_checks = 0, seed = 9206, wk_n = 0, p;
	int map_q[$] = '{12'hBFB, 12'hAA9, 12'hAA9, 12'hAA9, 12'hAA9, 12'hAA9};
	int cause_q[$] = '{0, 3, 4, 6, 7, 8};
	initial forever #5 clk = ~clk;
	rwd_top rwd_top_inst (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .ext_src, .reset_pin_n, .reset_pin_drive_n, .reset_pin_oe,
		.grp_rst, .lp_enter, .lp_mode, .wake_pins, .wake_mods, .wake_req, .sram_retain,
		.periph_power, .flash_cfg_byte, .uid_fuses, .dbg_mem_req, .dbg_mem_grant,
		.boot_read_req, .boot_read_grant, .mass_erase_set, .mass_erase_done,
		.mass_erase_start, .irq);
	rwd_pin_model rwd_pin_model_inst (.reset_pin_drive_n, .reset_pin_oe, .press, .reset_pin_n);
	always @(posedge clk) if (wake_req === 1'b1) wk_n++;
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			$display("unexpected %0t: apb timeout", $time);
			end_sim();
		end
		rv = prdata;
		psel <= 0;
		penable <= 0;
		`CHK(pslverr, (a == 12'h030))
	endtask : apb
	task automatic rel();
		int k = 0;
		while (grp_rst !== 12'h000 && k < 60) begin
			@(posedge clk);
			#1;
			k++;
		end
		`CHK(k, 16)
		if (k >= 60) end_sim();
	endtask : rel
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		uid_fuses = 80'({$random(seed), $random(seed), $random(seed)});
		repeat (20) @(posedge clk);
		#1 `CHK(grp_rst, 12'hFFF)
		`CHK(reset_pin_oe, 1'b1)
		@(posedge clk) rst <= 0;
		#1 rel();
		apb(0, `RWD_OFF_UID0, 0);
		`CHK(rv, uid_fuses[31:0])
		apb(0, `RWD_OFF_UID2, 0);
		`CHK(rv, {16'h0000, uid_fuses[79:64]})
		apb(0, 12'h030, 0);
		`CHK(dbg_mem_grant, 1'b0)
		`CHK(boot_read_grant, 1'b0)
		@(posedge clk) mass_erase_set <= 1;
		@(posedge clk) mass_erase_set <= 0;
		#1 `CHK(mass_erase_start, 1'b1)
		@(posedge clk) mass_erase_done <= 1;
		@(posedge clk) mass_erase_done <= 0;
		`WAITU(dbg_mem_grant === 1'b1)
		`CHK(boot_read_grant, 1'b1)
		@(posedge clk) dbg_mem_req <= 0;
		repeat (2) @(posedge clk);
		#1 `CHK(dbg_mem_grant, 1'b0)
		$display("security done");
		apb(1, `RWD_OFF_CAUSE, 32'h3FF);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk) ext_src <= 6'(1 << (5 - i));
			@(posedge clk) ext_src <= '0;
			#1 `CHK(grp_rst, 12'(map_q[i]))
			`CHK(reset_pin_oe, 1'b1)
			rel();
			apb(0, `RWD_OFF_CAUSE, 0);
			`CHK(rv, 32'(1 << cause_q[i]))
			`CHK(irq, 1'b0)
			apb(1, `RWD_OFF_CAUSE, rv);
		end
		apb(1, `RWD_OFF_CTRL, 32'h1);
		`WAITU(grp_rst === 12'hAA9)
		`WAITU(grp_rst === 12'h000)
		@(posedge clk) press <= 1;
		@(posedge clk) press <= 0;
		`WAITU(grp_rst === 12'hAB9)
		`CHK(reset_pin_oe, 1'b1)
		`WAITU(grp_rst === 12'h000)
		apb(0, `RWD_OFF_CAUSE, 0);
		`CHK(rv, 32'h24)
		apb(1, `RWD_OFF_CAUSE, 32'h3FF);
		$display("sources done");
		p = {$random(seed)} % 8;
		apb(1, `RWD_OFF_WAKE_EN, 32'(1 << p));
		apb(1, `RWD_OFF_MASK, 32'h200);
		@(posedge clk) wake_pins <= 8'(1 << p);
		repeat (4) @(posedge clk);
		#1 `CHK(wk_n, 0)
		@(posedge clk) wake_pins <= '0;
		lp_enter <= 1;
		@(posedge clk) lp_enter <= 0;
		wake_pins <= 8'(1 << p);
		`WAITU(wk_n == 1)
		repeat (4) @(posedge clk);
		#1 `CHK(wk_n, 1)
		`CHK(irq, 1'b1)
		@(posedge clk) wake_pins <= '0;
		apb(0, `RWD_OFF_WAKE_FLAGS, 0);
		`CHK(rv, 32'(1 << p))
		apb(1, `RWD_OFF_WAKE_FLAGS, 32'h1FFF);
		apb(1, `RWD_OFF_CAUSE, 32'h200);
		repeat (2) @(posedge clk);
		#1 `CHK(irq, 1'b0)
		$display("leak stop done");
		for (int k = 0; k < 3; k++) begin
			rf_d = $random(seed);
			apb(1, `RWD_OFF_RF, rf_d);
			apb(1, `RWD_OFF_WAKE_EN, 32'h200);
			@(posedge clk) lp_enter <= 1;
			lp_mode <= (k == 1) ? rwd_pkg::LP_DEEP_STOP0 :
				(k == 2) ? rwd_pkg::LP_DEEP_STOP3 : rwd_pkg::LP_DEEP_STOP1;
			@(posedge clk) lp_enter <= 0;
			`WAITU(periph_power === 1'b0)
			`CHK(sram_retain, (k == 2))
			@(posedge clk) press <= (k == 1);
			wake_mods <= (k == 1) ? 4'h0 : 4'h2;
			`WAITU(grp_rst === 12'h231)
			`CHK(reset_pin_oe, (k == 1))
			`CHK(reset_pin_drive_n, 1'b0)
			@(posedge clk) press <= 0;
			wake_mods <= '0;
			`WAITU(grp_rst === 12'h000)
			apb(0, `RWD_OFF_RF, 0);
			`CHK(rv, rf_d)
			apb(0, `RWD_OFF_WAKE_FLAGS, 0);
			`CHK(rv, ((k == 1) ? 32'h1000 : 32'h200))
			apb(0, `RWD_OFF_STATE, 0);
			`CHK(rv[3:0], 4'h8)
			apb(1, `RWD_OFF_WAKE_FLAGS, 32'h1FFF);
			apb(0, `RWD_OFF_STATE, 0);
			`CHK(rv[3:0], 4'h1)
			`CHK(periph_power, 1'b1)
		end
		$display("deep stop done");
		end_sim();
	end
endmodule : reset_wakeup_distribution_tb
bind rwd_top rwd_chk rwd_chk_inst (.clk, .rst, .ext_src, .reset_pin_oe, .grp_rst, .wake_req,
	.sram_retain, .periph_power, .dbg_mem_req, .dbg_mem_grant, .mass_erase_set,
	.mass_erase_start);

// >>> testbench/rwd_chk.sv
`timescale 1ns/1ns
module rwd_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// watched ports
	input wire rwd_pkg::rwd_ext_src_s ext_src,
	input wire logic reset_pin_oe,
	input wire rwd_pkg::rwd_grp_s grp_rst,
	input wire logic wake_req,
	input wire logic sram_retain,
	input wire logic periph_power,
	input wire logic dbg_mem_req,
	input wire logic dbg_mem_grant,
	input wire logic mass_erase_set,
	input wire logic mass_erase_start
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence six_hit;
		ext_src.watchdog_timeout || ext_src.stop_ack_error || ext_src.lockup
			|| ext_src.debug_port_system_reset || ext_src.debug;
	endsequence
	six_map_a: assert property (six_hit |=> (grp_rst & 12'hAA9) == 12'hAA9 && reset_pin_oe)
		else $error("six-source map wrong");
	low_map_a: assert property (ext_src.low_voltage_detect |=> (grp_rst & 12'hBFB) == 12'hBFB)
		else $error("low-voltage map wrong");
	por_only_a: assert property ($rose(grp_rst.rtc || grp_rst.power_thresholds) |-> $past(rst))
		else $error("rtc or thresholds hit");
	tmr_src_a: assert property ($rose(grp_rst.low_power_timer) |-> $past(ext_src.low_voltage_detect || rst))
		else $error("timer reset wrongly");
	wake_map_a: assert property ($rose(grp_rst.others) && !reset_pin_oe |-> !grp_rst.power_controller && !grp_rst.mode_controller && !grp_rst.low_leakage_wakeup_unit)
		else $error("wakeup reset map wrong");
	wake_once_a: assert property (wake_req |=> !wake_req [*2])
		else $error("wake pulse repeated");
	deep_pwr_a: assert property (!sram_retain |-> !periph_power)
		else $error("sram lost while powered");
	sec_grant_a: assert property (dbg_mem_grant |-> $past(dbg_mem_req))
		else $error("grant without request");
	erase_go_a: assert property (mass_erase_set |=> mass_erase_start)
		else $error("erase not launched");
	rel_sync_a: assert property ($fell(grp_rst.others) |-> $past(grp_rst.others, 16))
		else $error("release too early");
endmodule : rwd_chk

// >>> testbench/rwd_pin_model.sv
`timescale 1ns/1ns
module rwd_pin_model (
	// from the block
	input wire logic reset_pin_drive_n,
	input wire logic reset_pin_oe,
	// board side
	input wire logic press,
	output logic reset_pin_n
);
	assign reset_pin_n = (press || (reset_pin_oe && !reset_pin_drive_n)) ? 1'b0 : 1'b1;
endmodule : rwd_pin_model
